// ==== hdl/dam_display_addr_mux.sv ====
// Display address multiplexer and third handshake output of the video controller.
//
// Summary of operation
// RL1: Independent mode drives handshake_out_c as active-low memory chip select.
// RL2: Transparent and shared modes drive handshake_out_c as active-low bus grant.
// RL3: Row buffer mode drives handshake_out_c high while row DMA is set up.
// RL4: Fourteen address lines; two extra high bits extend range to 64k.
// RL5: Address outputs float during intervals chosen by buffer mode.
// RL6: Row control fields are valid at falling edge of blanking.
// RL7: Address line 0 carries graphics mode flag in control phase.
// RL8: Address lines 1 and 2 carry address bits 14 and 15.
// RL9: Address line 3 marks the last active character row.
// RL10: Address lines 4 to 7 carry the scan line number.
// RL11: Address line 8 marks blanking before first scan line of row.
// RL12: Address line 9 marks a double width character row.
// RL13: Address line 10 marks blanking before the programmed underline line.
// RL14: Address line 11 carries blink signal divided from vertical sync.
// RL15: With interlace, address line 12 marks odd field lines.
// RL16: Address line 13 marks blanking before last scan line of row.
// RL17: CPU drives its request low to access display memory.
// RL18: Blanking output high during borders; its fall is the sample point.
// RL19: Grant only after address outputs float; release when request withdrawn.
`timescale 1ns/1ps

module dam_display_addr_mux (
  input  wire logic                  clk_sys,
  input  wire logic                  reset_n,
  input  wire logic                  clk_en,
  input  wire dam_pkg::dam_mode_t    buffer_mode,
  input  wire logic                  border_active,
  input  wire logic                  vsync_pulse,
  input  wire logic [13:0]           char_addr,
  input  wire logic                  char_addr_valid,
  input  wire dam_pkg::dam_row_ctl_t row_ctl,
  input  wire logic                  cpu_bus_req_n,
  input  wire logic                  mem_access,
  input  wire logic                  row_dma_setup,
  output logic                       blank_out,
  output logic [13:0]                disp_addr,
  output logic                       disp_addr_oe_n,
  output logic                       handshake_out_c
);

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  function automatic logic is_cpu_mode(input dam_pkg::dam_mode_t m);
    is_cpu_mode = (m == dam_pkg::DAM_MODE_TRANSP) || (m == dam_pkg::DAM_MODE_SHARED);
  endfunction

  function automatic logic [13:0] ctl_word(input dam_pkg::dam_row_ctl_t c,
                                           input logic                  blink);
    logic [13:0] w;
    logic [3:0]  ln;
    w  = '0;
    ln = c.scanline_num;
    w[dam_pkg::BIT_GRAPHICS]                       = c.graphics_flag;
    w[dam_pkg::BIT_EXT14]                          = c.ext_addr[0];
    w[dam_pkg::BIT_EXT15]                          = c.ext_addr[1];
    w[dam_pkg::BIT_FINAL_ROW]                      = c.final_row_flag;
    w[dam_pkg::BIT_LINE_LO +: 4]                   = ln;
    w[dam_pkg::BIT_FIRST]                          = (ln == 4'h0);
    w[dam_pkg::BIT_WIDE]                           = c.wide_row_flag;
    w[dam_pkg::BIT_UNDERLINE]                      = (ln == c.underline_pos);
    w[dam_pkg::BIT_BLINK]                          = blink;
    w[dam_pkg::BIT_ODD]                            = c.interlace & c.odd_field;
    w[dam_pkg::BIT_LAST]                           = (ln == c.last_line);
    ctl_word = w;
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    DAM_BUS_OWN,
    DAM_BUS_FLOAT,
    DAM_BUS_GRANT
  } dam_bus_t;

  dam_bus_t    bus_state;
  dam_bus_t    next_bus_state;
  logic [5:0]  blink_cnt;
  logic [5:0]  next_blink_cnt;
  logic        blink;
  logic        next_blink;
  logic        vsync_prev;
  logic        next_vsync_prev;
  logic [13:0] next_disp_addr;
  logic        next_disp_addr_oe_n;
  logic        next_blank_out;
  logic        next_handshake_out_c;

  // ----------------------------------------------------------------------
  // Next-value logic
  // ----------------------------------------------------------------------
  always_comb begin
    next_bus_state  = bus_state;
    next_blink_cnt  = blink_cnt;
    next_blink      = blink;
    next_vsync_prev = vsync_pulse;
    // Blink toggles after a fixed number of vertical syncs.
    if (vsync_pulse && !vsync_prev) begin // RL14
      if (blink_cnt == dam_pkg::BLINK_DIV - 6'h01) begin
        next_blink_cnt = dam_pkg::BLINK_RESET;
        next_blink     = ~blink;
      end else begin
        next_blink_cnt = blink_cnt + 6'h01;
      end
    end
    // Bus ownership follows the CPU request in the shared-memory modes.
    case (bus_state)
      DAM_BUS_OWN: begin
        if (is_cpu_mode(buffer_mode) && !cpu_bus_req_n) begin // RL17
          next_bus_state = DAM_BUS_FLOAT;
        end
      end
      DAM_BUS_FLOAT: begin
        if (cpu_bus_req_n || !is_cpu_mode(buffer_mode)) begin
          next_bus_state = DAM_BUS_OWN;
        end else begin
          next_bus_state = DAM_BUS_GRANT; // RL19
        end
      end
      DAM_BUS_GRANT: begin
        if (cpu_bus_req_n || !is_cpu_mode(buffer_mode)) begin
          next_bus_state = DAM_BUS_OWN; // RL19
        end
      end
      default: next_bus_state = DAM_BUS_OWN;
    endcase

    next_blank_out = border_active; // RL18
    // Control word during borders, character address otherwise.
    if (border_active) begin
      next_disp_addr = ctl_word(row_ctl, blink); // RL6 RL7 RL8 RL9 RL10 RL11 RL12 RL13 RL15 RL16
    end else begin
      next_disp_addr = char_addr; // RL4
    end
    // Float while the CPU owns the bus or when no address is due.
    next_disp_addr_oe_n = 1'b0;
    if (next_bus_state != DAM_BUS_OWN || (!border_active && !char_addr_valid)) begin
      next_disp_addr_oe_n = 1'b1; // RL5
    end

    case (buffer_mode)
      dam_pkg::DAM_MODE_INDEP:  next_handshake_out_c = ~mem_access; // RL1
      dam_pkg::DAM_MODE_ROWBUF: next_handshake_out_c = row_dma_setup; // RL3
      default:                  next_handshake_out_c = ~(next_bus_state == DAM_BUS_GRANT); // RL2
    endcase
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bus_state       <= DAM_BUS_OWN;
      blink_cnt       <= dam_pkg::BLINK_RESET;
      blink           <= 1'b0;
      vsync_prev      <= 1'b0;
      disp_addr       <= dam_pkg::ADDR_RESET;
      disp_addr_oe_n  <= 1'b1;
      blank_out       <= 1'b1;
      handshake_out_c <= 1'b1;
    end else if (clk_en) begin
      bus_state       <= next_bus_state;
      blink_cnt       <= next_blink_cnt;
      blink           <= next_blink;
      vsync_prev      <= next_vsync_prev;
      disp_addr       <= next_disp_addr;
      disp_addr_oe_n  <= next_disp_addr_oe_n;
      blank_out       <= next_blank_out;
      handshake_out_c <= next_handshake_out_c;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_grant_after_float: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL19
    ($past(clk_en) && is_cpu_mode($past(buffer_mode)) && !handshake_out_c) |-> disp_addr_oe_n)
    else $error("Bus grant given while address outputs driven.");

  a_grant_released: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL2
    (clk_en && is_cpu_mode(buffer_mode) && cpu_bus_req_n && $stable(buffer_mode))
      |=> handshake_out_c)
    else $error("Bus grant held after request withdrawn.");

  a_grant_given: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL2
    (clk_en && is_cpu_mode(buffer_mode) && !cpu_bus_req_n)[*3] |-> !handshake_out_c)
    else $error("Bus grant not given to steady request.");

  a_chip_select: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL1
    (clk_en && buffer_mode == dam_pkg::DAM_MODE_INDEP) |=> handshake_out_c == !$past(mem_access))
    else $error("Chip select does not follow memory access.");

  a_row_dma: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL3
    (clk_en && buffer_mode == dam_pkg::DAM_MODE_ROWBUF) |=> handshake_out_c == $past(row_dma_setup))
    else $error("Row DMA control does not follow setup.");

  a_blank_follow: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL18
    clk_en |=> blank_out == $past(border_active))
    else $error("Blanking output does not follow border.");

  a_line_field: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL10
    (clk_en && border_active) |=> disp_addr[7:4] == $past(row_ctl.scanline_num))
    else $error("Scan line number missing from control word.");

  a_first_line: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL11
    (clk_en && border_active) |=> disp_addr[8] == ($past(row_ctl.scanline_num) == 4'h0))
    else $error("First line flag wrong.");

  a_odd_field: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL15
    (clk_en && border_active && !row_ctl.interlace) |=> !disp_addr[12])
    else $error("Odd field flag set without interlace.");

  a_char_addr: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL4
    (clk_en && !border_active) |=> disp_addr == $past(char_addr))
    else $error("Character address not passed through.");

  // ----------------------------------------------------------------------
  // Control word assertions
  // ----------------------------------------------------------------------
  a_graphics_bit: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL7
    (clk_en && border_active) |=> disp_addr[0] == $past(row_ctl.graphics_flag))
    else $error("Graphics flag missing from control word.");

  a_ext_bits: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL8
    (clk_en && border_active) |=> disp_addr[2:1] == $past(row_ctl.ext_addr))
    else $error("Extended address bits missing from control word.");

  a_final_row: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL9
    (clk_en && border_active) |=> disp_addr[3] == $past(row_ctl.final_row_flag))
    else $error("Final row flag missing from control word.");

  a_wide_row: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL12
    (clk_en && border_active) |=> disp_addr[9] == $past(row_ctl.wide_row_flag))
    else $error("Double width flag missing from control word.");

  a_underline_bit: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL13
    (clk_en && border_active) |=> disp_addr[10] ==
      ($past(row_ctl.scanline_num) == $past(row_ctl.underline_pos)))
    else $error("Underline flag wrong.");

  a_blink_bit: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL14
    (clk_en && border_active) |=> disp_addr[11] == $past(blink))
    else $error("Blink signal missing from control word.");

  a_odd_set: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL15
    (clk_en && border_active && row_ctl.interlace && row_ctl.odd_field) |=> disp_addr[12])
    else $error("Odd field flag missing with interlace.");

  a_last_line: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL16
    (clk_en && border_active) |=> disp_addr[13] ==
      ($past(row_ctl.scanline_num) == $past(row_ctl.last_line)))
    else $error("Last line flag wrong.");

  // ----------------------------------------------------------------------
  // Address drive and bus ownership assertions
  // ----------------------------------------------------------------------
  a_float_owned: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL5
    (bus_state != DAM_BUS_OWN) |-> disp_addr_oe_n)
    else $error("Address outputs driven while bus given away.");

  a_float_idle: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL5
    (clk_en && !border_active && !char_addr_valid) |=> disp_addr_oe_n)
    else $error("Address outputs driven with no address due.");

  a_drive_border: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL5
    (clk_en && border_active && bus_state == DAM_BUS_OWN
      && !(is_cpu_mode(buffer_mode) && !cpu_bus_req_n)) |=> !disp_addr_oe_n)
    else $error("Address outputs not driven during border.");

  a_drive_char: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL4
    (clk_en && !border_active && char_addr_valid && bus_state == DAM_BUS_OWN
      && !(is_cpu_mode(buffer_mode) && !cpu_bus_req_n)) |=> !disp_addr_oe_n)
    else $error("Address outputs not driven for a valid address.");

  a_grant_float: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL19
    ($fell(handshake_out_c) && is_cpu_mode($past(buffer_mode))) |-> $past(disp_addr_oe_n))
    else $error("Bus grant given before address outputs floated.");

  a_release_own: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL19
    (clk_en && is_cpu_mode(buffer_mode) && cpu_bus_req_n) |=> bus_state == DAM_BUS_OWN)
    else $error("Bus not taken back after request withdrawn.");

  a_own_other: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL2
    (clk_en && !is_cpu_mode(buffer_mode)) |=> bus_state == DAM_BUS_OWN)
    else $error("Bus given away outside the shared-memory modes.");

  a_float_first: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL19
    (clk_en && bus_state == DAM_BUS_OWN && is_cpu_mode(buffer_mode) && !cpu_bus_req_n)
      |=> (bus_state == DAM_BUS_FLOAT) && handshake_out_c && disp_addr_oe_n)
    else $error("Request not answered by floating the address outputs.");

  a_grant_step: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL2
    (clk_en && bus_state == DAM_BUS_FLOAT && is_cpu_mode(buffer_mode) && !cpu_bus_req_n)
      |=> (bus_state == DAM_BUS_GRANT) && !handshake_out_c)
    else $error("Bus grant not given after float.");

  a_float_release: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL19
    (clk_en && bus_state == DAM_BUS_FLOAT && cpu_bus_req_n)
      |=> (bus_state == DAM_BUS_OWN) && handshake_out_c)
    else $error("Withdrawn request still floats the bus.");

  a_grant_held: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL2
    (clk_en && bus_state == DAM_BUS_GRANT && is_cpu_mode(buffer_mode) && !cpu_bus_req_n)
      |=> (bus_state == DAM_BUS_GRANT) && !handshake_out_c && disp_addr_oe_n)
    else $error("Bus grant dropped while request held.");

  a_state_legal: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL19
    bus_state inside {DAM_BUS_OWN, DAM_BUS_FLOAT, DAM_BUS_GRANT})
    else $error("Bus ownership state out of range.");

  // ----------------------------------------------------------------------
  // Blanking, blink and clock enable assertions
  // ----------------------------------------------------------------------
  a_blank_rise: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL18
    $rose(blank_out) |-> $past(border_active))
    else $error("Blanking rose outside a border.");

  a_blank_fall: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL18
    $fell(blank_out) |-> !$past(border_active))
    else $error("Blanking fell inside a border.");

  a_blink_toggle: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL14
    (clk_en && vsync_pulse && !vsync_prev && blink_cnt == dam_pkg::BLINK_DIV - 6'h01)
      |=> (blink != $past(blink)) && (blink_cnt == dam_pkg::BLINK_RESET))
    else $error("Blink did not toggle at end of count.");

  a_blink_hold: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL14
    (clk_en && !(vsync_pulse && !vsync_prev)) |=> $stable(blink) && $stable(blink_cnt))
    else $error("Blink divider moved without a vertical sync.");

  a_blink_count: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL14
    (clk_en && vsync_pulse && !vsync_prev && blink_cnt != dam_pkg::BLINK_DIV - 6'h01)
      |=> (blink_cnt == $past(blink_cnt) + 6'h01) && $stable(blink))
    else $error("Blink divider did not count a vertical sync.");

  a_blink_range: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL14
    blink_cnt < dam_pkg::BLINK_DIV)
    else $error("Blink divider out of range.");

  a_vsync_track: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL14
    clk_en |=> vsync_prev == $past(vsync_pulse))
    else $error("Vertical sync edge detector out of step.");

  a_freeze_outputs: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !clk_en |=> $stable(disp_addr) && $stable(blank_out) && $stable(disp_addr_oe_n)
      && $stable(handshake_out_c))
    else $error("Outputs changed while clock enable low.");

  a_freeze_state: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !clk_en |=> $stable(bus_state) && $stable(blink_cnt) && $stable(blink))
    else $error("State changed while clock enable low.");

endmodule

// ==== hdl/dam_pkg.sv ====
// Package with modes, control-word layout and timing constants for the display address mux.
package dam_pkg;

  // ----------------------------------------------------------------------
  // Buffer modes
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    DAM_MODE_INDEP,
    DAM_MODE_TRANSP,
    DAM_MODE_SHARED,
    DAM_MODE_ROWBUF
  } dam_mode_t;

  // ----------------------------------------------------------------------
  // Address widths and control bit positions
  // ----------------------------------------------------------------------
  localparam int ADDR_W        = 14;
  localparam int BIT_GRAPHICS  = 0;
  localparam int BIT_EXT14     = 1;
  localparam int BIT_EXT15     = 2;
  localparam int BIT_FINAL_ROW = 3;
  localparam int BIT_LINE_LO   = 4;
  localparam int BIT_FIRST     = 8;
  localparam int BIT_WIDE      = 9;
  localparam int BIT_UNDERLINE = 10;
  localparam int BIT_BLINK     = 11;
  localparam int BIT_ODD       = 12;
  localparam int BIT_LAST      = 13;

  // ----------------------------------------------------------------------
  // Reset values and timing counts
  // ----------------------------------------------------------------------
  localparam logic [13:0] ADDR_RESET   = 14'h0000;
  localparam logic [5:0]  BLINK_DIV    = 6'h10;
  localparam logic [5:0]  BLINK_RESET  = 6'h00;
  localparam int          GRANT_DELAY  = 1;

  // ----------------------------------------------------------------------
  // Per-row control information from the timing logic
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       graphics_flag;
    logic [1:0] ext_addr;
    logic       final_row_flag;
    logic [3:0] scanline_num;
    logic [3:0] underline_pos;
    logic       wide_row_flag;
    logic       interlace;
    logic       odd_field;
    logic [3:0] last_line;
  } dam_row_ctl_t;

endpackage

// ==== verification/dam_far_side_model.sv ====
// Far side model: CPU bus requester and external row control latch.
`timescale 1ns/1ps
module dam_far_side_model (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        req_go,
  input  wire logic        blank_out,
  input  wire logic [13:0] disp_addr,
  input  wire logic        handshake_out_c,
  output logic             cpu_bus_req_n,
  output logic [13:0]      row_latch
);
  logic [13:0] shadow;
  logic        grant_seen;
  logic        go_seen;
  initial begin
    cpu_bus_req_n = 1'b1;
    row_latch = 14'h0000;
    shadow = 14'h0000;
  end
  // The request is held low until the grant is sampled at a clock edge, then withdrawn.
  always @(posedge clk_sys) begin
    grant_seen = !handshake_out_c;
    go_seen = req_go;
    #1;
    if (!cpu_bus_req_n && grant_seen) cpu_bus_req_n = 1'b1;
    else if (go_seen && reset_n) cpu_bus_req_n = 1'b0;
  end
  always @(negedge clk_sys) begin
    if (blank_out) shadow = disp_addr;
  end
  // The control word is taken at the falling end of blanking.
  always @(negedge blank_out) begin
    row_latch = shadow;
  end
endmodule

// ==== verification/tb_top.sv ====
// Self-checking testbench for the display address multiplexer.
`timescale 1ns/1ps
module tb_top;
  logic                  clk_sys, reset_n, clk_en, border_active, vsync_pulse;
  logic                  char_addr_valid, mem_access, row_dma_setup, req_go, blink;
  logic                  blank_out, disp_addr_oe_n, handshake_out_c, cpu_bus_req_n;
  logic [13:0]           char_addr, row_latch, disp_addr;
  dam_pkg::dam_mode_t    buffer_mode;
  dam_pkg::dam_row_ctl_t row_ctl;
  int                    num_errors, n_tests, k;
  always #2.5 clk_sys = ~clk_sys;
  dam_display_addr_mux dut (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
    .buffer_mode(buffer_mode), .border_active(border_active), .vsync_pulse(vsync_pulse),
    .char_addr(char_addr), .char_addr_valid(char_addr_valid), .row_ctl(row_ctl),
    .cpu_bus_req_n(cpu_bus_req_n), .mem_access(mem_access), .row_dma_setup(row_dma_setup),
    .blank_out(blank_out), .disp_addr(disp_addr), .disp_addr_oe_n(disp_addr_oe_n),
    .handshake_out_c(handshake_out_c));
  dam_far_side_model far (.clk_sys(clk_sys), .reset_n(reset_n), .req_go(req_go),
    .blank_out(blank_out), .disp_addr(disp_addr), .handshake_out_c(handshake_out_c),
    .cpu_bus_req_n(cpu_bus_req_n), .row_latch(row_latch));
  task automatic check(input logic [13:0] seen, input logic [13:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask
  function automatic logic [13:0] ctl_word(input dam_pkg::dam_row_ctl_t r, input logic b);
    return {r.scanline_num == r.last_line, r.interlace & r.odd_field, b,
            r.scanline_num == r.underline_pos, r.wide_row_flag, r.scanline_num == 4'h0,
            r.scanline_num, r.final_row_flag, r.ext_addr, r.graphics_flag};
  endfunction
  task automatic end_sim();
    $display("errors=%0d tests=%0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    end_sim();
  end
  initial begin
    clk_sys = 1'b0;
    reset_n = 1'b0;
    clk_en = 1'b1;
    border_active = 1'b1;
    {vsync_pulse, char_addr_valid, mem_access, row_dma_setup, req_go, blink} = 6'h00;
    char_addr = 14'h0000;
    row_ctl = '0;
    buffer_mode = dam_pkg::DAM_MODE_INDEP;
    num_errors = 0;
    n_tests = 0;
    k = $urandom(30176);
    repeat (10) step();
    check({13'h0000, disp_addr_oe_n}, 14'h0001);
    reset_n = 1'b1;
    for (int i = 0; i < 40; i++) begin
      row_ctl = 19'($urandom);
      if (i % 4 == 1) row_ctl.underline_pos = row_ctl.scanline_num;
      if (i % 4 == 2) row_ctl.last_line = row_ctl.scanline_num;
      if (i % 4 == 3) row_ctl.scanline_num = 4'h0;
      border_active = 1'b1;
      mem_access = 1'($urandom);
      char_addr = 14'($urandom);
      char_addr_valid = 1'b1;
      step();
      check(disp_addr, ctl_word(row_ctl, blink));
      check({13'h0000, blank_out}, 14'h0001);
      check({13'h0000, handshake_out_c}, {13'h0000, ~mem_access});
      border_active = 1'b0;
      step();
      check(row_latch, ctl_word(row_ctl, blink));
      check(disp_addr, char_addr);
      check({12'h000, disp_addr_oe_n, blank_out}, 14'h0000);
      char_addr_valid = 1'b0;
      step();
      check({13'h0000, disp_addr_oe_n}, 14'h0001);
    end
    clk_en = 1'b0;
    border_active = 1'b1;
    char_addr_valid = 1'b1;
    repeat (3) step();
    check({12'h000, disp_addr_oe_n, blank_out}, 14'h0002);
    clk_en = 1'b1;
    repeat (2) begin
      for (int j = 0; j < 16; j++) begin
        vsync_pulse = 1'b1;
        step();
        vsync_pulse = 1'b0;
        step();
        if (j == 14) check({13'h0000, disp_addr[11]}, {13'h0000, blink});
      end
      blink = ~blink;
      step();
      check({13'h0000, disp_addr[11]}, {13'h0000, blink});
    end
    buffer_mode = dam_pkg::DAM_MODE_ROWBUF;
    repeat (8) begin
      row_dma_setup = 1'($urandom);
      step();
      check({13'h0000, handshake_out_c}, {13'h0000, row_dma_setup});
    end
    for (int m = 1; m < 3; m++) begin
      buffer_mode = dam_pkg::dam_mode_t'(m);
      border_active = 1'b0;
      char_addr_valid = 1'b1;
      step();
      req_go = 1'b1;
      k = 0;
      while (handshake_out_c !== 1'b0 && k < 20) begin
        step();
        k++;
      end
      req_go = 1'b0;
      check({13'h0000, handshake_out_c}, 14'h0000);
      check({13'h0000, disp_addr_oe_n}, 14'h0001);
      k = 0;
      while (handshake_out_c !== 1'b1 && k < 5) begin
        step();
        k++;
      end
      check({12'h000, handshake_out_c, disp_addr_oe_n}, 14'h0002);
    end
    end_sim();
  end
endmodule
